// >>> verilog/dtc_pkg.sv
// shared constants and types of the dual time base capture/compare unit
// assumes a single 125 MHz clock that also serves as the cpu clock
package dtc_pkg;

  // channel and timer sizes
  localparam int NCH = 8;
  localparam int NPAIR = 4;
  localparam int TW = 16;
  localparam int AW = 8;

  // resolution: one cpu_state_time is half a clock period
  localparam int TCL_PER_CLK = 2;
  localparam int RES_TCL = 16;
  localparam int BASE_DIV = (RES_TCL + TCL_PER_CLK - 1) / TCL_PER_CLK;
  localparam int PRE_W = 10;

  // register byte offsets
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_CNT0 = 8'h04;
  localparam logic [AW-1:0] ADDR_RLD0 = 8'h08;
  localparam logic [AW-1:0] ADDR_CNT1 = 8'h0c;
  localparam logic [AW-1:0] ADDR_RLD1 = 8'h10;
  localparam logic [AW-1:0] ADDR_CFG_LO = 8'h14;
  localparam logic [AW-1:0] ADDR_CFG_HI = 8'h18;
  localparam logic [AW-1:0] ADDR_IRQ = 8'h1c;
  localparam logic [AW-1:0] ADDR_PIN = 8'h20;
  localparam logic [AW-1:0] ADDR_CHAN = 8'h40;

  // control register fields
  localparam int CTRL_RUN_LSB = 0;
  localparam int CTRL_PRE0_LSB = 4;
  localparam int CTRL_PRE1_LSB = 8;
  localparam int CTRL_DBL_LSB = 12;
  // channel configuration byte fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_TSEL_BIT = 4;
  // pin status register fields
  localparam int PIN_IN_LSB = 0;
  localparam int PIN_OUT_LSB = 8;
  localparam int PIN_OE_LSB = 16;

  // reset values and the top count of the timers
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [TW-1:0] RELOAD_RST = 16'h0000;
  localparam logic [TW-1:0] CHAN_RST = 16'h0000;
  localparam logic [TW-1:0] CNT_RST = 16'h0000;
  localparam logic [TW-1:0] CNT_MAX = 16'hffff;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // channel modes
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    CAP_RISE = 3'h1,
    CAP_FALL = 3'h2,
    CAP_BOTH = 3'h3,
    CMP_IRQ = 3'h4,
    CMP_TOG = 3'h5,
    CMP_IRQ_ONCE = 3'h6,
    CMP_SET = 3'h7
  } dtc_mode_t;

  // axi4-lite request from the master
  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } dtc_axi_req_t;

  // axi4-lite answer of the slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dtc_axi_rsp_t;

endpackage

// >>> verilog/dtc_timer.sv
// one 16-bit time base with prescaler and reload register
// assumes run, prescale and reload come from registers in the same domain
module dtc_timer (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic run,
  input wire logic [2:0] prescale,
  input wire logic [dtc_pkg::TW-1:0] reload,
  // software write of the count
  input wire logic wr_cnt,
  input wire logic [dtc_pkg::TW-1:0] wr_data,
  // time base outputs
  output logic [dtc_pkg::TW-1:0] cnt,
  output logic upd,
  output logic ovf
);
  import dtc_pkg::*;

  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;
  logic [TW-1:0] next_cnt;
  logic next_upd;
  logic next_ovf;
  logic [PRE_W-1:0] limit;

  // prescaler never ticks faster than the base resolution
  assign limit = PRE_W'(BASE_DIV) << prescale; // see R1

  // count, reload on overflow; a software write wins over a tick
  always_comb begin
    next_pre = pre;
    next_cnt = cnt;
    next_upd = 1'b0;
    next_ovf = 1'b0;
    if (!run) begin
      next_pre = '0;
    end else if (pre == limit - PRE_W'(1)) begin
      next_pre = '0;
      next_upd = 1'b1;
      if (cnt == CNT_MAX) begin
        next_cnt = reload; // see R14
        next_ovf = 1'b1;
      end else begin
        next_cnt = cnt + TW'(1); // see R2
      end
    end else begin
      next_pre = pre + PRE_W'(1);
    end
    if (wr_cnt) begin
      next_cnt = wr_data;
      next_upd = 1'b0;
      next_ovf = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre <= '0;
      cnt <= CNT_RST;
      upd <= 1'b0;
      ovf <= 1'b0;
    end else begin
      pre <= next_pre;
      cnt <= next_cnt;
      upd <= next_upd;
      ovf <= next_ovf;
    end
  end

  // cycles since the last update, for the spacing check
  logic [PRE_W:0] gap;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap <= '0;
    end else if (upd) begin
      gap <= '0;
    end else if (gap != '1) begin
      gap <= gap + (PRE_W+1)'(1);
    end
  end

  reload_take_a: assert property (@(posedge clk) disable iff (!arst_n)
    ovf |-> (upd && cnt == $past(reload) && $past(cnt) == CNT_MAX))
    else $error("overflow did not load the reload value"); // see R14
  tick_space_a: assert property (@(posedge clk) disable iff (!arst_n)
    (upd && $past(upd, 2) == 1'b0 && gap != '0) |-> gap >= 7)
    else $error("timer updated faster than the resolution"); // see R1

endmodule

// >>> verilog/dtc_top.sv
// eight channel capture/compare unit with two time base timers
// assumes an axi4-lite master on REF_CLK and pins synchronous to REF_CLK
//
// How it works
// R1: eight channels, timer steps at least 16 cpu_state_times
// R2: two independent 16-bit timers with reload registers
// R3: each channel picks timer and capture/compare mode
// R4: one pin per channel, input or output
// R5: capture latches assigned timer count on edge
// R6: each capture sets its channel request flag
// R7: capture edge selectable rising, falling or both
// R8: compare channels match on every timer update
// R9: mode 0 interrupts every match, pin undriven
// R10: mode 1 toggles pin every match
// R11: mode 2 interrupts once per timer period
// R12: mode 3 sets pin on match, clears on overflow
// R13: double mode pairs channels, lower pin toggles
// R14: overflow reloads timer and ends the period
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
module dtc_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // register bus
  input wire dtc_pkg::dtc_axi_req_t S_AXI_REQ,
  output dtc_pkg::dtc_axi_rsp_t S_AXI_RSP,
  // channel pins
  input wire logic [dtc_pkg::NCH-1:0] CC_PIN_I,
  output logic [dtc_pkg::NCH-1:0] CC_PIN_O,
  output logic [dtc_pkg::NCH-1:0] CC_PIN_OE,
  // per-channel request flags
  output logic [dtc_pkg::NCH-1:0] IRQ_REQ
);
  import dtc_pkg::*;

  // merge write data into a word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // channel register address of channel n
  function automatic logic [AW-1:0] chan_addr(input int n);
    return ADDR_CHAN + AW'(4 * n);
  endfunction

  // register state
  logic [31:0] ctrl;
  logic [TW-1:0] reload0;
  logic [TW-1:0] reload1;
  logic [NCH-1:0] tsel;
  dtc_mode_t mode [NCH];
  logic [TW-1:0] chan [NCH];
  logic [NCH-1:0] once_done;
  logic [NCH-1:0] pin_prev;
  logic [31:0] next_ctrl;
  logic [TW-1:0] next_reload0;
  logic [TW-1:0] next_reload1;
  logic [NCH-1:0] next_tsel;
  dtc_mode_t next_mode [NCH];
  logic [TW-1:0] next_chan [NCH];
  logic [NCH-1:0] next_once_done;
  logic [NCH-1:0] next_pin_o;
  logic [NCH-1:0] next_pin_oe;
  logic [NCH-1:0] next_irq;
  dtc_axi_rsp_t next_rsp;

  // timer outputs
  logic [TW-1:0] cnt0;
  logic [TW-1:0] cnt1;
  logic upd0;
  logic upd1;
  logic ovf0;
  logic ovf1;

  // write strobe decode
  logic wr_go;
  logic [AW-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic wr_cnt0;
  logic wr_cnt1;
  logic [31:0] cnt0_w;
  logic [31:0] cnt1_w;

  assign wr_go = S_AXI_RSP.awready;
  assign wa = S_AXI_REQ.awaddr;
  assign wd = S_AXI_REQ.wdata;
  assign ws = S_AXI_REQ.wstrb;
  assign wr_cnt0 = wr_go && wa == ADDR_CNT0;
  assign wr_cnt1 = wr_go && wa == ADDR_CNT1;
  assign cnt0_w = merge({16'h0000, cnt0}, wd, ws);
  assign cnt1_w = merge({16'h0000, cnt1}, wd, ws);

  // the two independent time bases
  dtc_timer u_tmr0 (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .run(ctrl[CTRL_RUN_LSB]),
    .prescale(ctrl[CTRL_PRE0_LSB +: 3]),
    .reload(reload0),
    .wr_cnt(wr_cnt0),
    .wr_data(cnt0_w[TW-1:0]),
    .cnt(cnt0),
    .upd(upd0),
    .ovf(ovf0)
  );
  dtc_timer u_tmr1 (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .run(ctrl[CTRL_RUN_LSB + 1]),
    .prescale(ctrl[CTRL_PRE1_LSB +: 3]),
    .reload(reload1),
    .wr_cnt(wr_cnt1),
    .wr_data(cnt1_w[TW-1:0]),
    .cnt(cnt1),
    .upd(upd1),
    .ovf(ovf1)
  );

  // address map check and read mux
  function automatic logic mapped(input logic [AW-1:0] a);
    logic hit;
    hit = a == ADDR_CTRL || a == ADDR_CNT0 || a == ADDR_RLD0 ||
          a == ADDR_CNT1 || a == ADDR_RLD1 || a == ADDR_CFG_LO ||
          a == ADDR_CFG_HI || a == ADDR_IRQ || a == ADDR_PIN;
    for (int n = 0; n < NCH; n++) begin
      if (a == chan_addr(n)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (S_AXI_REQ.araddr)
      ADDR_CTRL: rd_word = ctrl;
      ADDR_CNT0: rd_word = {16'h0000, cnt0};
      ADDR_RLD0: rd_word = {16'h0000, reload0};
      ADDR_CNT1: rd_word = {16'h0000, cnt1};
      ADDR_RLD1: rd_word = {16'h0000, reload1};
      ADDR_IRQ: rd_word = {24'h00_0000, IRQ_REQ};
      default: rd_word = 32'h0000_0000;
    endcase
    if (S_AXI_REQ.araddr == ADDR_PIN) begin
      rd_word[PIN_IN_LSB +: NCH] = CC_PIN_I;
      rd_word[PIN_OUT_LSB +: NCH] = CC_PIN_O;
      rd_word[PIN_OE_LSB +: NCH] = CC_PIN_OE;
    end
    for (int n = 0; n < NCH; n++) begin
      if (S_AXI_REQ.araddr == (n < 4 ? ADDR_CFG_LO : ADDR_CFG_HI)) begin
        rd_word[8*(n%4) + CFG_MODE_LSB +: 3] = mode[n];
        rd_word[8*(n%4) + CFG_TSEL_BIT] = tsel[n];
      end
      if (S_AXI_REQ.araddr == chan_addr(n)) begin
        rd_word = {16'h0000, chan[n]};
      end
    end
  end

  // bus slave: address and data taken together, answer follows
  always_comb begin
    next_rsp = S_AXI_RSP;
    if (S_AXI_RSP.awready) begin
      next_rsp.awready = 1'b0;
      next_rsp.wready = 1'b0;
      next_rsp.bvalid = 1'b1;
      next_rsp.bresp = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
    end else if (!S_AXI_RSP.bvalid && S_AXI_REQ.awvalid &&
                 S_AXI_REQ.wvalid) begin
      next_rsp.awready = 1'b1;
      next_rsp.wready = 1'b1;
    end
    if (S_AXI_RSP.bvalid && S_AXI_REQ.bready) begin
      next_rsp.bvalid = 1'b0;
    end
    if (S_AXI_RSP.arready) begin
      next_rsp.arready = 1'b0;
      next_rsp.rvalid = 1'b1;
      next_rsp.rdata = rd_word;
      next_rsp.rresp = mapped(S_AXI_REQ.araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (!S_AXI_RSP.rvalid && S_AXI_REQ.arvalid) begin
      next_rsp.arready = 1'b1;
    end
    if (S_AXI_RSP.rvalid && S_AXI_REQ.rready) begin
      next_rsp.rvalid = 1'b0;
    end
  end

  // per-channel events, shared by the next-state logic and the checks
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] match;
  logic [NCH-1:0] ovf_sel;
  logic [NCH-1:0] cmp_ev;
  logic [NPAIR-1:0] dbl;
  logic [TW-1:0] cnt_sel [NCH];
  assign dbl = ctrl[CTRL_DBL_LSB +: NPAIR];

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cnt_sel[i] = tsel[i] ? cnt1 : cnt0; // see R3
      ovf_sel[i] = tsel[i] ? ovf1 : ovf0;
      // edge choice on the channel pin
      case (mode[i])
        CAP_RISE: cap_ev[i] = CC_PIN_I[i] && !pin_prev[i]; // see R7
        CAP_FALL: cap_ev[i] = !CC_PIN_I[i] && pin_prev[i]; // see R7
        CAP_BOTH: cap_ev[i] = CC_PIN_I[i] != pin_prev[i]; // see R7
        default: cap_ev[i] = 1'b0;
      endcase
      // compare on each update of the assigned timer
      match[i] = mode[i][2] && (tsel[i] ? upd1 : upd0) &&
                 cnt_sel[i] == chan[i]; // see R8
      // once-per-period modes drop matches after the first
      cmp_ev[i] = match[i] && !((mode[i] == CMP_IRQ_ONCE ||
                  mode[i] == CMP_SET) && once_done[i] &&
                  !ovf_sel[i]); // see R11 see R12
    end
  end

  // register writes, captures, compare actions and flags
  always_comb begin
    next_ctrl = ctrl;
    next_reload0 = reload0;
    next_reload1 = reload1;
    next_tsel = tsel;
    next_once_done = once_done;
    next_pin_o = CC_PIN_O;
    next_pin_oe = '0;
    next_irq = IRQ_REQ;
    for (int i = 0; i < NCH; i++) begin
      next_mode[i] = mode[i];
      next_chan[i] = chan[i];
    end
    if (wr_go) begin
      if (wa == ADDR_CTRL) next_ctrl = merge(ctrl, wd, ws);
      if (wa == ADDR_RLD0) next_reload0 = TW'(merge({16'h0000, reload0},
                                                    wd, ws));
      if (wa == ADDR_RLD1) next_reload1 = TW'(merge({16'h0000, reload1},
                                                    wd, ws));
      if (wa == ADDR_IRQ) next_irq = IRQ_REQ & ~(wd[NCH-1:0] &
                                                 {NCH{ws[0]}});
    end
    for (int i = 0; i < NCH; i++) begin
      // configuration byte of channel i
      if (wr_go && ws[i%4] &&
          wa == (i < 4 ? ADDR_CFG_LO : ADDR_CFG_HI)) begin
        next_mode[i] = dtc_mode_t'(wd[8*(i%4) + CFG_MODE_LSB +: 3]);
        next_tsel[i] = wd[8*(i%4) + CFG_TSEL_BIT];
      end
      if (wr_go && wa == chan_addr(i)) begin
        next_chan[i] = TW'(merge({16'h0000, chan[i]}, wd, ws));
      end
      // a capture wins over a software write in the same cycle
      if (cap_ev[i]) begin
        next_chan[i] = cnt_sel[i]; // see R5
      end
      // overflow ends the period, a match in that cycle still counts
      if (ovf_sel[i]) next_once_done[i] = 1'b0; // see R14
      if (cmp_ev[i] && mode[i][1]) next_once_done[i] = 1'b1; // see R11
      // hardware set wins over the software clear
      if (cap_ev[i] || cmp_ev[i]) next_irq[i] = 1'b1; // see R6 see R9
    end
    for (int p = 0; p < NPAIR; p++) begin
      if (dbl[p]) begin
        // both registers of the pair toggle the lower pin
        if ((cmp_ev[p] || cmp_ev[p+NPAIR]) && mode[p][2]) begin
          next_pin_o[p] = !CC_PIN_O[p]; // see R13
        end
        next_pin_oe[p] = mode[p][2]; // see R13
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if (!(i < NPAIR && dbl[i]) && !(i >= NPAIR && dbl[i%NPAIR])) begin
        case (mode[i])
          CMP_TOG: begin
            next_pin_oe[i] = 1'b1; // see R4
            if (cmp_ev[i]) next_pin_o[i] = !CC_PIN_O[i]; // see R10
          end
          CMP_SET: begin
            next_pin_oe[i] = 1'b1; // see R4
            if (ovf_sel[i]) next_pin_o[i] = 1'b0; // see R12
            if (cmp_ev[i]) next_pin_o[i] = 1'b1; // see R12
          end
          default: next_pin_oe[i] = 1'b0; // see R9
        endcase
      end
    end
  end

  // register everything on every edge
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_RSP <= '0;
      ctrl <= CTRL_RST;
      reload0 <= RELOAD_RST;
      reload1 <= RELOAD_RST;
      tsel <= '0;
      once_done <= '0;
      pin_prev <= '0;
      CC_PIN_O <= '0;
      CC_PIN_OE <= '0;
      IRQ_REQ <= '0;
      for (int i = 0; i < NCH; i++) begin
        mode[i] <= MODE_OFF;
        chan[i] <= CHAN_RST;
      end
    end else begin
      S_AXI_RSP <= next_rsp;
      ctrl <= next_ctrl;
      reload0 <= next_reload0;
      reload1 <= next_reload1;
      tsel <= next_tsel;
      once_done <= next_once_done;
      pin_prev <= CC_PIN_I;
      CC_PIN_O <= next_pin_o;
      CC_PIN_OE <= next_pin_oe;
      IRQ_REQ <= next_irq;
      for (int i = 0; i < NCH; i++) begin
        mode[i] <= next_mode[i];
        chan[i] <= next_chan[i];
      end
    end
  end

  // checks on each channel
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    sequence rise_seen;
      mode[g] == CAP_RISE && CC_PIN_I[g] && !pin_prev[g];
    endsequence
    sequence period_end;
      ovf_sel[g] && mode[g] == CMP_SET && !match[g];
    endsequence
    cap_latch_a: assert property (cap_ev[g] |=> // see R5
      chan[g] == $past(cnt_sel[g]))
      else $error("capture did not latch the timer count");
    cap_flag_a: assert property (cap_ev[g] |=> IRQ_REQ[g]) // see R6
      else $error("capture did not set the request flag");
    edge_rise_a: assert property (rise_seen |-> cap_ev[g]) // see R7
      else $error("rising edge missed");
    cap_pin_a: assert property (!mode[g][2] |=> !CC_PIN_OE[g]) // see R4
      else $error("pin driven while capturing");
    m0_irq_a: assert property (match[g] && mode[g] == CMP_IRQ |=> // see R9
      IRQ_REQ[g] && (!CC_PIN_OE[g] || g < NPAIR && dbl[g % NPAIR]))
      else $error("mode 0 match lost or pin driven");
    m2_once_a: assert property (mode[g] == CMP_IRQ_ONCE && // see R11
      once_done[g] && !ovf_sel[g] |-> !cmp_ev[g])
      else $error("second mode 2 event in one period");
    m3_clear_a: assert property (period_end |=> // see R12
      (!CC_PIN_O[g] || $past(mode[g]) != mode[g] || g < NPAIR &&
      dbl[g % NPAIR] || g >= NPAIR && dbl[g % NPAIR]))
      else $error("mode 3 pin not cleared on overflow");
    if (g < NPAIR) begin : g_pair
      m1_tog_a: assert property (cmp_ev[g] && mode[g] == CMP_TOG && // see R10
        !dbl[g] && $stable(mode[g]) ##1 $stable(mode[g]) |->
        CC_PIN_O[g] != $past(CC_PIN_O[g]))
        else $error("mode 1 match did not toggle the pin");
      dbl_tog_a: assert property (dbl[g] && mode[g][2] && // see R13
        cmp_ev[g+NPAIR] |=> CC_PIN_O[g] != $past(CC_PIN_O[g]))
        else $error("paired register did not toggle the lower pin");
    end
  end

endmodule

// >>> test/dtc_pin_model.sv
// far side of the channel pins: an external source that makes edges
// assumes the bench asks for a level and the unit drives only where oe
module dtc_pin_model (
  // clock
  input wire logic clk,
  // requested levels and the unit's own pin drive
  input wire logic [7:0] level,
  input wire logic [7:0] o,
  input wire logic [7:0] oe,
  // resolved pin levels seen by the unit
  output logic [7:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drive;

  // edges change just after a clock edge, never mid-cycle
  always_ff @(posedge clk) begin
    drive <= level;
  end

  // a driven pin shows the unit's value, an input pin the source's
  assign pin_i = (oe & o) | (~oe & drive);
endmodule

// >>> test/test_dual_timebase_capture_compare.sv
// self-checking bench for the dual time base capture/compare unit
// assumes dtc_top on REF_CLK with the pin model on its channel pins
module test_dual_timebase_capture_compare;
  timeunit 1ns;
  timeprecision 1ps;
  import dtc_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  dtc_axi_req_t req = '0;
  dtc_axi_rsp_t rsp;
  logic [NCH-1:0] pin_i, pin_o, pin_oe, irq;
  logic [NCH-1:0] level = 8'h00;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] rdat;
  logic [1:0] resp;
  int n;
  logic p0;
  localparam logic [7:0] RST_A [8] = '{ADDR_CTRL, ADDR_CNT0, ADDR_RLD0,
    ADDR_CNT1, ADDR_RLD1, ADDR_CFG_LO, ADDR_IRQ, ADDR_CHAN};
  localparam logic [7:0] CFG_A [9] = '{ADDR_RLD0, ADDR_CNT0, 8'h40,
    8'h44, 8'h48, 8'h4c, 8'h50, ADDR_CFG_LO, ADDR_CFG_HI};
  localparam logic [31:0] CFG_D [9] = '{32'hfff8, 32'hfff8, 32'hfffa,
    32'hfffe, 32'hfffa, 32'hfffa, 32'hfffc, 32'h0604_0705, 32'h1312_1105};

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  dtc_top DUT (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .S_AXI_REQ(req), .S_AXI_RSP(rsp),
    .CC_PIN_I(pin_i), .CC_PIN_O(pin_o), .CC_PIN_OE(pin_oe), .IRQ_REQ(irq));

  dtc_pin_model far_side (
    .clk(ref_clk), .level(level), .o(pin_o), .oe(pin_oe), .pin_i(pin_i));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // each channel released only once the slave has taken it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int k;
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && k < 100);
    req.bready <= 1'b0;
    if (k >= 100) chk(32'h1, 32'h0, "write stall");
    chk({30'h0, rsp.bresp}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int k;
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && k < 100);
    req.rready <= 1'b0;
    d = rsp.rdata;
    r = rsp.rresp;
    if (k >= 100) chk(32'h1, 32'h0, "read stall");
  endtask

  // counts edges until a pin (src 0) or flag (src 1) shows lvl
  task automatic wait_lvl(input int src, input int i, input logic lvl,
                          output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      cnt++;
    end while (((src == 0) ? pin_o[i] : irq[i]) !== lvl && cnt < 2000);
    if (cnt >= 2000) chk(32'h1, 32'h0, "wait timeout");
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    foreach (RST_A[i]) begin
      rd(RST_A[i], rdat, resp);
      chk(rdat, 32'h0, "reset value");
      chk({30'h0, resp}, {30'h0, RESP_OKAY}, "read response");
    end
    rd(8'h3c, rdat, resp);
    chk(rdat, 32'h0, "unmapped read");
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped response");
    wr(8'h3c, 32'h1, RESP_SLVERR);
    wr(ADDR_PIN, 32'hffff_ffff, RESP_OKAY);
    rd(ADDR_PIN, rdat, resp);
    chk(rdat, 32'h0, "pin status read only");
    // timer0 slowed to 32 cycles a tick so bus writes fit between matches
    foreach (CFG_A[i]) wr(CFG_A[i], CFG_D[i], RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk({24'h0, pin_oe}, 32'h13, "pin directions");
    wr(ADDR_CTRL, 32'h21, RESP_OKAY);
    // second match in one period: mode 0 flags again, mode 2 does not
    wait_lvl(1, 3, 1'b1, n);
    wr(ADDR_IRQ, 32'h0c, RESP_OKAY);
    wr(8'h48, 32'hfffd, RESP_OKAY);
    wr(8'h4c, 32'hfffd, RESP_OKAY);
    wait_lvl(0, 1, 1'b1, n);
    chk({30'h0, irq[3:2]}, 32'h1, "once per period");
    p0 = pin_o[0];
    wait_lvl(0, 1, 1'b0, n);
    chk(n, 64, "set to overflow");
    wait_lvl(0, 1, 1'b1, n);
    chk(n, 192, "overflow to set");
    chk({31'h0, irq[3]}, 32'h1, "new period flag");
    chk({31'h0, pin_o[0]}, {31'h0, ~p0}, "toggle each period");
    // pair 0 in double mode toggles twice a period
    wr(ADDR_CTRL, 32'h1021, RESP_OKAY);
    wait_lvl(0, 1, 1'b0, n);
    wait_lvl(0, 1, 1'b1, n);
    p0 = pin_o[0];
    wait_lvl(0, 1, 1'b0, n);
    wait_lvl(0, 1, 1'b1, n);
    chk({31'h0, pin_o[0]}, {31'h0, p0}, "double toggle");
    chk({31'h0, pin_oe[4]}, 32'h0, "upper pin released");
    // captures on the stopped timer1 so the latched count is exact
    wr(ADDR_IRQ, 32'he0, RESP_OKAY);
    wr(ADDR_CNT1, 32'h1234, RESP_OKAY);
    @(posedge ref_clk);
    level <= 8'he0;
    repeat (4) @(posedge ref_clk);
    chk({29'h0, irq[7:5]}, 32'h5, "rising flags");
    chk({29'h0, pin_oe[7:5]}, 32'h0, "capture pins input");
    wr(ADDR_IRQ, 32'he0, RESP_OKAY);
    wr(ADDR_CNT1, 32'h5678, RESP_OKAY);
    @(posedge ref_clk);
    level <= 8'h00;
    repeat (4) @(posedge ref_clk);
    chk({29'h0, irq[7:5]}, 32'h6, "falling flags");
    rd(8'h54, rdat, resp);
    chk(rdat, 32'h1234, "rise capture");
    rd(8'h58, rdat, resp);
    chk(rdat, 32'h5678, "fall capture");
    rd(8'h5c, rdat, resp);
    chk(rdat, 32'h5678, "both capture");
    // timer1 runs beside timer0 from its top count into its own reload value
    wr(ADDR_RLD1, 32'h4321, RESP_OKAY);
    wr(ADDR_CNT1, 32'hffff, RESP_OKAY);
    wr(ADDR_CTRL, 32'h1023, RESP_OKAY);
    repeat (8) @(posedge ref_clk);
    wr(ADDR_CTRL, 32'h1021, RESP_OKAY);
    rd(ADDR_CNT1, rdat, resp);
    chk(rdat, 32'h4321, "timer1 reload");
    report_and_stop();
  end

  // the whole run needs somewhat over a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end
endmodule
